// >>> hdl/frp_pkg.sv
// Shared constants for the FIFO read port with rewind
package frp_pkg;

  // Default geometry: 524288 words of 36 bits
  localparam int unsigned FRP_ADDR_W = 19;
  localparam int unsigned FRP_DATA_W = 36;

  // Number of pin inputs passed through the synchroniser bank
  localparam int unsigned FRP_PIN_N = 10;

  // Bit positions of each pin in the synchroniser vector
  localparam int unsigned FRP_PIN_REN_N   = 0;
  localparam int unsigned FRP_PIN_SEL_N   = 1;
  localparam int unsigned FRP_PIN_REWIND  = 2;
  localparam int unsigned FRP_PIN_MARK    = 3;
  localparam int unsigned FRP_PIN_OE_N    = 4;
  localparam int unsigned FRP_PIN_STROBE  = 5;
  localparam int unsigned FRP_PIN_FULL_N  = 6;
  localparam int unsigned FRP_PIN_PART_N  = 7;
  localparam int unsigned FRP_PIN_FALL    = 8;
  localparam int unsigned FRP_PIN_ASYNC   = 9;

  // Level each synchroniser stage holds under reset: all inputs idle
  localparam logic [FRP_PIN_N-1:0] FRP_PIN_IDLE = 10'h0_D3;

  // Pointer value that reset and an unmarked rewind load
  localparam logic [FRP_ADDR_W:0] FRP_PTR_ZERO = 20'h0_0000;

  // Output register value after full or partial reset
  localparam logic [FRP_DATA_W-1:0] FRP_DATA_ZERO = 36'h0_0000_0000;

endpackage

// >>> hdl/frp_pin_if.sv
// Synchronised pin levels passed from the synchroniser bank to the read port
`timescale 1ns/1ps
`default_nettype none
interface frp_pin_if;
  logic read_enable_n;
  logic read_select_n;
  logic rewind_request;
  logic mark;
  logic output_enable_n;
  logic read_strobe;
  logic full_reset_n;
  logic partial_clear_n;
  logic first_word_fall_through;
  logic async_read;

  modport src (
    output read_enable_n,
    output read_select_n,
    output rewind_request,
    output mark,
    output output_enable_n,
    output read_strobe,
    output full_reset_n,
    output partial_clear_n,
    output first_word_fall_through,
    output async_read
  );

  modport dst (
    input read_enable_n,
    input read_select_n,
    input rewind_request,
    input mark,
    input output_enable_n,
    input read_strobe,
    input full_reset_n,
    input partial_clear_n,
    input first_word_fall_through,
    input async_read
  );
endinterface
`default_nettype wire

// >>> hdl/frp_pin_sync.sv
// Two-flop synchroniser bank for the read port's pin inputs
`timescale 1ns/1ps
`default_nettype none
module frp_pin_sync
  import frp_pkg::*;
(
  input  wire logic                 clock_i,
  input  wire logic                 rstn_i,
  input  wire logic [FRP_PIN_N-1:0] pins_i,
  frp_pin_if.src                    pin_o
);

  typedef struct packed {
    logic [FRP_PIN_N-1:0] meta;
    logic [FRP_PIN_N-1:0] sync;
  } frp_sync_state_t;

  frp_sync_state_t state_q;
  frp_sync_state_t state_d;

  always_comb begin
    state_d      = state_q;
    state_d.meta = pins_i;
    state_d.sync = state_q.meta;
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= '{meta: FRP_PIN_IDLE, sync: FRP_PIN_IDLE};
    end else begin
      state_q <= state_d;
    end
  end

  assign pin_o.read_enable_n           = state_q.sync[FRP_PIN_REN_N];
  assign pin_o.read_select_n           = state_q.sync[FRP_PIN_SEL_N];
  assign pin_o.rewind_request          = state_q.sync[FRP_PIN_REWIND];
  assign pin_o.mark                    = state_q.sync[FRP_PIN_MARK];
  assign pin_o.output_enable_n         = state_q.sync[FRP_PIN_OE_N];
  assign pin_o.read_strobe             = state_q.sync[FRP_PIN_STROBE];
  assign pin_o.full_reset_n            = state_q.sync[FRP_PIN_FULL_N];
  assign pin_o.partial_clear_n         = state_q.sync[FRP_PIN_PART_N];
  assign pin_o.first_word_fall_through = state_q.sync[FRP_PIN_FALL];
  assign pin_o.async_read              = state_q.sync[FRP_PIN_ASYNC];

endmodule
`default_nettype wire

// >>> hdl/frp_read_port.sv
// Read-port control of a dual-port FIFO: sync/async reads, select, mark and rewind
`timescale 1ns/1ps
`default_nettype none

module frp_read_port
  import frp_pkg::*;
#(
  parameter int unsigned ADDR_W = FRP_ADDR_W,
  parameter int unsigned DATA_W = FRP_DATA_W
) (
  input  wire logic              clock_i,
  input  wire logic              rstn_i,
  input  wire logic              read_enable_n_i,
  input  wire logic              read_select_n_i,
  input  wire logic              read_strobe_i,
  input  wire logic              rewind_request_i,
  input  wire logic              mark_i,
  input  wire logic              output_enable_n_i,
  input  wire logic              full_reset_n_i,
  input  wire logic              partial_clear_n_i,
  input  wire logic              first_word_fall_through_i,
  input  wire logic              async_read_i,
  input  wire logic              offset_load_n_i,
  input  wire logic [DATA_W-1:0] offset_data_i,
  input  wire logic [ADDR_W:0]   write_ptr_i,
  input  wire logic [DATA_W-1:0] mem_rdata_i,
  output logic      [ADDR_W-1:0] mem_raddr_o,
  output logic      [DATA_W-1:0] read_data_out_o,
  output logic                   read_data_oe_n_o,
  output logic                   empty_flag_n_o,
  output logic                   output_ready_n_o,
  output logic                   fifo_reset_busy_o
);

  typedef struct packed {
    logic [ADDR_W:0]   rd_ptr;
    logic [ADDR_W:0]   mark_ptr;
    logic              mark_set;
    logic [DATA_W-1:0] data;
    logic              empty_n;
    logic              ready_n;
    logic              fall_thru;
    logic              async_rd;
    logic              sel_n;
    logic              strobe;
    logic              rewind;
  } frp_state_t;

  frp_pin_if pin ();

  logic [FRP_PIN_N-1:0] pins_raw;

  // Pack the pins into one vector for the synchroniser bank
  always_comb begin
    pins_raw                 = FRP_PIN_IDLE;
    pins_raw[FRP_PIN_REN_N]  = read_enable_n_i;
    pins_raw[FRP_PIN_SEL_N]  = read_select_n_i;
    pins_raw[FRP_PIN_REWIND] = rewind_request_i;
    pins_raw[FRP_PIN_MARK]   = mark_i;
    pins_raw[FRP_PIN_OE_N]   = output_enable_n_i;
    pins_raw[FRP_PIN_STROBE] = read_strobe_i;
    pins_raw[FRP_PIN_FULL_N] = full_reset_n_i;
    pins_raw[FRP_PIN_PART_N] = partial_clear_n_i;
    pins_raw[FRP_PIN_FALL]   = first_word_fall_through_i;
    pins_raw[FRP_PIN_ASYNC]  = async_read_i;
  end

  frp_pin_sync frp_pin_sync_inst (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .pins_i  (pins_raw),
    .pin_o   (pin.src)
  );

  // Pointer step with wrap through the extra lap bit
  function automatic logic [ADDR_W:0] ptr_inc(input logic [ADDR_W:0] p);
    return p + {{ADDR_W{1'b0}}, 1'b1};
  endfunction

  frp_state_t state_q;
  frp_state_t state_d;

  logic in_reset;
  logic mem_empty;
  logic rewind_evt;
  logic strobe_evt;
  logic sync_req;
  logic take_word;
  logic fall_load;

  assign in_reset  = !pin.full_reset_n || !pin.partial_clear_n;
  // Pointers equal, lap bit included: nothing left to read
  assign mem_empty = (state_q.rd_ptr == write_ptr_i);

  assign rewind_evt = pin.rewind_request && !state_q.rewind;
  // A strobe pulse shorter than one clock period may be missed
  assign strobe_evt = pin.read_strobe && !state_q.strobe;

  assign sync_req = !state_q.async_rd && !pin.read_enable_n && !state_q.sel_n;

  always_comb begin
    state_d        = state_q;
    state_d.strobe = pin.read_strobe;
    state_d.rewind = pin.rewind_request;
    state_d.sel_n  = pin.read_select_n;
    take_word      = 1'b0;
    fall_load      = 1'b0;

    if (!pin.full_reset_n) begin
      // Mode straps are caught while full reset is held
      state_d.fall_thru = pin.first_word_fall_through;
      state_d.async_rd  = pin.async_read;
    end

    if (in_reset) begin
      // reset clears pointer, mark and output
      state_d.rd_ptr   = FRP_PTR_ZERO;
      state_d.mark_ptr = FRP_PTR_ZERO;
      state_d.mark_set = 1'b0;
      state_d.data     = FRP_DATA_ZERO;
      state_d.empty_n  = 1'b0;
      state_d.ready_n  = 1'b1;
    end else if (rewind_evt) begin
      state_d.rd_ptr  = state_q.mark_set ? state_q.mark_ptr : FRP_PTR_ZERO;
      // Mark capture is skipped in the rewind cycle
      // rewind flag indication
      state_d.empty_n = 1'b0;
      state_d.ready_n = 1'b1;
    end else begin
      if (state_q.async_rd) begin
        take_word = strobe_evt && !mem_empty;
      end else if (sync_req && !offset_load_n_i) begin
        state_d.data = offset_data_i;
      end else if (state_q.fall_thru) begin
        // Fall-through: refill output when empty or consumed
        fall_load = !mem_empty && (state_q.ready_n || sync_req);
        if (sync_req && !state_q.ready_n && mem_empty) begin
          state_d.ready_n = 1'b1;
        end
      end else begin
        take_word = sync_req && !mem_empty;
      end

      if (take_word || fall_load) begin
        state_d.data   = mem_rdata_i;
        state_d.rd_ptr = ptr_inc(state_q.rd_ptr);
      end
      if (fall_load) begin
        state_d.ready_n = 1'b0;
      end

      state_d.empty_n = !(state_d.rd_ptr == write_ptr_i);

      if (pin.mark) begin
        state_d.mark_ptr = state_q.rd_ptr;
        state_d.mark_set = 1'b1;
      end
    end
  end

  // Edge trackers reset to idle pin levels, so no false edge follows reset
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= '{
        rd_ptr:   FRP_PTR_ZERO,
        mark_ptr: FRP_PTR_ZERO,
        mark_set: 1'b0,
        data:     FRP_DATA_ZERO,
        empty_n:  1'b0,
        ready_n:  1'b1,
        fall_thru: 1'b0,
        async_rd: 1'b0,
        sel_n:    1'b1,
        strobe:   1'b0,
        rewind:   1'b0
      };
    end else begin
      state_q <= state_d;
    end
  end

  // Memory address drops the lap bit
  assign mem_raddr_o       = state_q.rd_ptr[ADDR_W-1:0];
  assign read_data_out_o   = state_q.data;
  assign fifo_reset_busy_o = in_reset;

  // flag presented for the active mode
  assign empty_flag_n_o   = state_q.fall_thru ? 1'b1 : state_q.empty_n;
  assign output_ready_n_o = state_q.fall_thru ? state_q.ready_n : 1'b1;

  // output enable alone controls drive in reset
  assign read_data_oe_n_o = in_reset ? pin.output_enable_n
                                     : (pin.output_enable_n || state_q.sel_n);

endmodule
`default_nettype wire

// >>> dv/frp_mem_model.sv
// Far-side memory model: word k holds a fixed pattern xor k
`timescale 1ns/1ps
`default_nettype none
module frp_mem_model #(
  parameter int unsigned AW = 19,
  parameter int unsigned DW = 36
) (
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);
  assign rdata_o = DW'(36'h5_A5A5_0000) ^ DW'(raddr_i);
endmodule
`default_nettype wire

// >>> dv/frp_read_port_chk.sv
// Checker for the read port top, bound to it
`timescale 1ns/1ps
`default_nettype none
module frp_read_port_chk #(
  parameter int unsigned ADDR_W = 19,
  parameter int unsigned DATA_W = 36
) (
  input wire logic              clock_i,
  input wire logic              rstn_i,
  input wire logic              read_enable_n_i,
  input wire logic              read_select_n_i,
  input wire logic              read_strobe_i,
  input wire logic              rewind_request_i,
  input wire logic              output_enable_n_i,
  input wire logic              full_reset_n_i,
  input wire logic              first_word_fall_through_i,
  input wire logic              offset_load_n_i,
  input wire logic [ADDR_W-1:0] mem_raddr_o,
  input wire logic [DATA_W-1:0] read_data_out_o,
  input wire logic              read_data_oe_n_o,
  input wire logic              empty_flag_n_o,
  input wire logic              output_ready_n_o,
  input wire logic              fifo_reset_busy_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  sequence sel_hi;
    read_select_n_i[*4] ##0 !$past(fifo_reset_busy_o) && !fifo_reset_busy_o;
  endsequence
  sequence idle4;
    (read_select_n_i && read_enable_n_i && !read_strobe_i)[*4];
  endsequence
  busy_enter_a: assert property (
    $fell(full_reset_n_i) |-> ##[2:3] fifo_reset_busy_o) else $error("busy late");
  reset_zero_a: assert property (
    fifo_reset_busy_o |=> read_data_out_o == '0 && mem_raddr_o == '0)
    else $error("not cleared in reset");
  reset_flags_a: assert property (
    fifo_reset_busy_o |=> output_ready_n_o
                          && (empty_flag_n_o == first_word_fall_through_i))
    else $error("reset flags");
  reset_drive_a: assert property (
    (!output_enable_n_i)[*3] ##0 fifo_reset_busy_o |-> !read_data_oe_n_o)
    else $error("outputs not driven in reset");
  sel_hiz_a: assert property (
    sel_hi |-> read_data_oe_n_o) else $error("driven while deselected");
  no_read_a: assert property (
    idle4 ##0 sel_hi |=> $stable(read_data_out_o)) else $error("read while idle");
  rewind_ready_a: assert property (
    !output_ready_n_o ##0 $rose(rewind_request_i) |-> ##[2:4] output_ready_n_o)
    else $error("ready not dropped on rewind");
  rewind_empty_a: assert property (
    (!first_word_fall_through_i && empty_flag_n_o) ##0 $rose(rewind_request_i)
    |-> ##[2:4] !empty_flag_n_o) else $error("empty not set on rewind");
  flag_excl_a: assert property (
    !empty_flag_n_o |-> output_ready_n_o) else $error("both flags active");
  data_pairs_a: assert property (
    $changed(read_data_out_o) && $past(offset_load_n_i) && !$past(fifo_reset_busy_o)
    |-> $changed(mem_raddr_o)) else $error("data moved without pointer");
endmodule
bind frp_read_port frp_read_port_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_inst (
  .clock_i                   (clock_i),
  .rstn_i                    (rstn_i),
  .read_enable_n_i           (read_enable_n_i),
  .read_select_n_i           (read_select_n_i),
  .read_strobe_i             (read_strobe_i),
  .rewind_request_i          (rewind_request_i),
  .output_enable_n_i         (output_enable_n_i),
  .full_reset_n_i            (full_reset_n_i),
  .first_word_fall_through_i (first_word_fall_through_i),
  .offset_load_n_i           (offset_load_n_i),
  .mem_raddr_o               (mem_raddr_o),
  .read_data_out_o           (read_data_out_o),
  .read_data_oe_n_o          (read_data_oe_n_o),
  .empty_flag_n_o            (empty_flag_n_o),
  .output_ready_n_o          (output_ready_n_o),
  .fifo_reset_busy_o         (fifo_reset_busy_o)
);
`default_nettype wire

// >>> dv/tb_frp_read_port.sv
// Self-checking bench for the FIFO read port
`timescale 1ns/1ps
`default_nettype none
module tb_frp_read_port;
  import frp_pkg::*;
  logic                  clock_i = 0, rstn_i = 0, stb = 0, rw = 0, mk = 0;
  logic                  ren_n = 1, sel_n = 1, oe_n = 0, fr_n = 1, pc_n = 1, ft = 0, as = 0;
  logic                  doe_n, empty_n, or_n, busy, ld_n = 1;
  logic [FRP_ADDR_W:0]   wp = 20'h0_0008;
  logic [FRP_ADDR_W-1:0] raddr;
  logic [FRP_DATA_W-1:0] rdata, dout, prev = '0, ofs = '0, ov;
  logic [FRP_DATA_W-1:0] exp_q[$];
  int                    n_errors = 0, checks_done = 0, n;
  frp_read_port frp_read_port_inst (.clock_i(clock_i), .rstn_i(rstn_i),
    .read_enable_n_i(ren_n), .read_select_n_i(sel_n), .read_strobe_i(stb),
    .rewind_request_i(rw), .mark_i(mk), .output_enable_n_i(oe_n), .full_reset_n_i(fr_n),
    .partial_clear_n_i(pc_n), .first_word_fall_through_i(ft), .async_read_i(as),
    .offset_load_n_i(ld_n), .offset_data_i(ofs), .write_ptr_i(wp),
    .mem_rdata_i(rdata), .mem_raddr_o(raddr), .read_data_out_o(dout),
    .read_data_oe_n_o(doe_n), .empty_flag_n_o(empty_n), .output_ready_n_o(or_n),
    .fifo_reset_busy_o(busy));
  frp_mem_model frp_mem_model_inst (.raddr_i(raddr), .rdata_o(rdata));
  always #2 clock_i = ~clock_i;
  function automatic logic [FRP_DATA_W-1:0] word(int k);
    return FRP_DATA_W'(36'h5_A5A5_0000) ^ FRP_DATA_W'(k);
  endfunction
  task automatic chk(string nm, logic [FRP_DATA_W-1:0] got, logic [FRP_DATA_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s exp=%h got=%h", nm, exp, got);
    end
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic cyc(int c);
    repeat (c) @(posedge clock_i);
  endtask
  // strobe in async mode, enable stays low there
  task automatic rd(int k, bit take);
    if (take) exp_q.push_back(word(k));
    if (as) stb <= 1'h1;
    else ren_n <= 1'h0;
    cyc(1);
    stb <= 1'h0;
    ren_n <= !as;
    cyc(7);
  endtask
  task automatic rewind;
    rw <= 1'h1;
    cyc(3);
    rw <= 1'h0;
    cyc(6);
  endtask
  task automatic frst(bit f, bit a, bit z);
    if (z) exp_q.push_back('0);
    if (f) exp_q.push_back(word(0));
    ft <= f;
    as <= a;
    ren_n <= !a;
    fr_n <= 1'h0;
    cyc(6);
    fr_n <= 1'h1;
    cyc(8);
  endtask
  always @(negedge clock_i) begin
    prev <= dout;
    if (rstn_i && dout !== prev) begin
      if (exp_q.size() == 0) chk("unexpected data", dout, prev);
      else chk("read data", dout, exp_q.pop_front());
    end
  end
  initial begin
    #20000;
    n_errors++;
    end_of_test();
  end
  initial begin
    void'($urandom(94));
    cyc(12);
    rstn_i <= 1'h1;
    cyc(3);
    frst(0, 0, 0);
    sel_n <= 1'h0;
    cyc(4);
    for (int k = 0; k < 3; k++) rd(k, 1);
    sel_n <= 1'h1;
    cyc(1);
    rd(3, 0);
    chk("oe_n deselected", doe_n, 1);
    sel_n <= 1'h0;
    mk <= 1'h1;
    cyc(1);
    mk <= 1'h0;
    cyc(5);
    rd(3, 1);
    rd(4, 1);
    rewind();
    chk("raddr at mark", raddr, 3);
    rd(3, 1);
    exp_q.push_back('0);
    sel_n <= 1'h1;
    pc_n <= 1'h0;
    cyc(5);
    chk("oe_n in reset", doe_n, 0);
    chk("busy", busy, 1);
    pc_n <= 1'h1;
    sel_n <= 1'h0;
    cyc(6);
    chk("raddr cleared", raddr, 0);
    wp <= 20'h0_0000;
    cyc(2);
    chk("empty_n at empty", empty_n, 0);
    rd(0, 0);
    chk("raddr refused", raddr, 0);
    wp <= 20'h0_0008;
    cyc(2);
    chk("empty_n refilled", empty_n, 1);
    rd(0, 1);
    rd(1, 1);
    rewind();
    chk("raddr rewound", raddr, 0);
    rd(0, 1);
    ov = {4'h9, $urandom()};
    ofs <= ov;
    ld_n <= 1'h0;
    exp_q.push_back(ov);
    rd(0, 0);
    ld_n <= 1'h1;
    chk("raddr after offset", raddr, 1);
    rd(1, 1);
    frst(0, 1, 1);
    n = $urandom_range(5, 2);
    for (int k = 0; k < n; k++) rd(k, 1);
    frst(1, 0, 1);
    chk("ready_n", or_n, 0);
    chk("empty_n", empty_n, 1);
    rd(1, 1);
    exp_q.push_back(word(0));
    rewind();
    cyc(4);
    chk("pending", exp_q.size(), 0);
    end_of_test();
  end
endmodule
`default_nettype wire
